// ---- logic/irq_route_pkg.sv ----
// constants, register map and types for the interrupt source router
package irq_route_pkg;
    localparam int NUM_PINS = 8;
    localparam int NUM_LEVELS = 8;
    localparam int NUM_SRC = 6;
    localparam int NUM_GRP = 4;
    localparam int LVL_W = 3;
    localparam int PT_W = 16;
    // register byte offsets
    localparam logic [7:0] OFS_PEND = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_EDGE = 8'h08;
    localparam logic [7:0] OFS_CTL_TB = 8'h0C;
    localparam logic [7:0] OFS_CTL_RTC = 8'h10;
    localparam logic [7:0] OFS_CTL_PT = 8'h14;
    localparam logic [7:0] OFS_CTL_LOCK = 8'h18;
    localparam logic [7:0] OFS_TB_REF0 = 8'h1C;
    localparam logic [7:0] OFS_TB_REF1 = 8'h20;
    localparam logic [7:0] OFS_RTC_ALARM = 8'h24;
    localparam logic [7:0] OFS_PT_RELOAD = 8'h28;
    localparam logic [7:0] OFS_TIO_LVL0 = 8'h2C;
    localparam logic [7:0] OFS_TIO_LVL1 = 8'h30;
    localparam logic [7:0] OFS_TIO_EN0 = 8'h34;
    localparam logic [7:0] OFS_TIO_EN1 = 8'h38;
    localparam logic [7:0] OFS_TIO_FLG0 = 8'h3C;
    localparam logic [7:0] OFS_TIO_FLG1 = 8'h40;
    // control register fields
    localparam int CTL_FLAG_A = 0;
    localparam int CTL_FLAG_B = 1;
    localparam int CTL_EN_A = 2;
    localparam int CTL_EN_B = 3;
    localparam int CTL_RUN = 4;
    localparam int CTL_LVL_LSB = 8;
    // internal source indices
    localparam int SRC_TB0 = 0;
    localparam int SRC_TB1 = 1;
    localparam int SRC_ALARM = 2;
    localparam int SRC_SEC = 3;
    localparam int SRC_PT = 4;
    localparam int SRC_LOCK = 5;
    localparam int GRP_PT = 2;
    // fixed channels per timer bank
    localparam logic [31:0] TIO_VALID0 = 32'h0000F84F;
    localparam logic [31:0] TIO_VALID1 = 32'hF84F0000;
    localparam logic [31:0] PIN0_BIT = 32'h80000000;
    localparam logic [31:0] RST_ZERO = 32'h00000000;
    localparam logic [PT_W-1:0] PT_RST_RELOAD = 16'hFFFF;
    typedef struct packed {
        logic [LVL_W-1:0] level;
        logic run;
        logic en_b;
        logic en_a;
        logic flag_b;
        logic flag_a;
    } ctl_view_s;
endpackage

// ---- logic/interrupt_source_routing.sv ----
// interrupt source router with apb register slave
module interrupt_source_routing #(
    parameter int TB_W = 32,
    parameter int RTC_W = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // request pins, active low
    input wire logic [irq_route_pkg::NUM_PINS-1:0] irq_pin_n,
    // internal event sources
    input wire logic [TB_W-1:0] tb_count,
    input wire logic [RTC_W-1:0] rtc_count,
    input wire logic rtc_second_tick,
    input wire logic pll_locked,
    input wire logic [31:0] tio_bank0_flags,
    input wire logic [31:0] tio_bank1_flags,
    // core requests
    output logic irq_req,
    output logic nmi_req
);
    localparam int NP = irq_route_pkg::NUM_PINS;
    localparam int NS = irq_route_pkg::NUM_SRC;
    localparam int LW = irq_route_pkg::LVL_W;

    function automatic logic [7:0] level_onehot(input logic [LW-1:0] lvl, input logic act);
        level_onehot = act ? (8'h01 << lvl) : 8'h00;
    endfunction

    function automatic int src_grp(input int s);
        src_grp = (s < 4) ? s / 2 : s - 2;
    endfunction

    function automatic bit src_is_b(input int s);
        src_is_b = (s < 4) && (s % 2 == 1);
    endfunction

    logic [31:0] interrupt_mask_register;
    logic [NP-1:0] edge_mode_reg;
    logic [NP-1:0] pin_pend_reg;
    logic [NP-1:0] pin_prev_reg;
    logic [NS-1:0] flag_reg;
    logic [NS-1:0] en_reg;
    logic [LW-1:0] level_reg [irq_route_pkg::NUM_GRP];
    logic pt_run_reg;
    logic [TB_W-1:0] tb_ref0_reg;
    logic [TB_W-1:0] tb_ref1_reg;
    logic [RTC_W-1:0] rtc_alarm_value;
    logic [irq_route_pkg::PT_W-1:0] pt_reload_reg;
    logic [irq_route_pkg::PT_W-1:0] pt_count_reg;
    logic [LW-1:0] tio_bank0_level;
    logic [LW-1:0] tio_bank1_level;
    logic [31:0] tio_bank0_enables;
    logic [31:0] tio_bank1_enables;
    logic lock_prev_reg;
    logic lock_seen_reg;
    logic [31:0] prdata_reg;
    logic irq_reg;
    logic [NS-1:0] set_evt;
    logic [7:0] lvl_req;
    logic [31:0] interrupt_pending_register;
    logic [31:0] rd_next;
    logic hit;
    logic wr;
    logic [NP-1:0] w1c_pin;
    logic tio0_act;
    logic tio1_act;

    // event detection
    assign set_evt[irq_route_pkg::SRC_TB0] = (tb_count == tb_ref0_reg);
    assign set_evt[irq_route_pkg::SRC_TB1] = (tb_count == tb_ref1_reg);
    assign set_evt[irq_route_pkg::SRC_ALARM] = (rtc_count == rtc_alarm_value);
    assign set_evt[irq_route_pkg::SRC_SEC] = rtc_second_tick;
    assign set_evt[irq_route_pkg::SRC_PT] = pt_run_reg && (pt_count_reg == '0);
    assign set_evt[irq_route_pkg::SRC_LOCK] = lock_seen_reg && (pll_locked != lock_prev_reg);

    assign tio0_act = |(tio_bank0_flags & tio_bank0_enables & irq_route_pkg::TIO_VALID0);
    assign tio1_act = |(tio_bank1_flags & tio_bank1_enables & irq_route_pkg::TIO_VALID1);

    // level requests from all internal sources
    always_comb
    begin
        lvl_req = level_onehot(tio_bank0_level, tio0_act) | level_onehot(tio_bank1_level, tio1_act);
        for (int s = 0; s < NS; s++)
        begin
            lvl_req = lvl_req | level_onehot(level_reg[src_grp(s)], flag_reg[s] && en_reg[s]);
        end
    end

    // pending word, pin i above level i
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++)
        begin : g_pend
            assign interrupt_pending_register[31-2*gi] = pin_pend_reg[gi];
            assign interrupt_pending_register[30-2*gi] = lvl_req[gi];
            // the low half has no sources and reads zero
            assign interrupt_pending_register[15-2*gi] = 1'b0;
            assign interrupt_pending_register[14-2*gi] = 1'b0;
            assign w1c_pin[gi] = wr && (paddr == irq_route_pkg::OFS_PEND) && pwdata[31-2*gi];
        end
    endgenerate

    // apb decode
    assign hit = (paddr[1:0] == 2'b00) && (paddr <= irq_route_pkg::OFS_TIO_FLG1);
    assign wr = psel && penable && pwrite && hit;
    // never stretched: every register answers at once
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    always_comb
    begin
        rd_next = irq_route_pkg::RST_ZERO;
        case (paddr)
            irq_route_pkg::OFS_PEND: rd_next = interrupt_pending_register;
            irq_route_pkg::OFS_MASK: rd_next = interrupt_mask_register;
            irq_route_pkg::OFS_EDGE: rd_next[NP-1:0] = edge_mode_reg;
            irq_route_pkg::OFS_CTL_TB, irq_route_pkg::OFS_CTL_RTC,
            irq_route_pkg::OFS_CTL_PT, irq_route_pkg::OFS_CTL_LOCK:
            begin
                for (int s = 0; s < NS; s++)
                begin
                    if (src_grp(s) == int'(paddr[4:2]) - 3)
                    begin
                        rd_next[src_is_b(s) ? irq_route_pkg::CTL_FLAG_B : irq_route_pkg::CTL_FLAG_A] = flag_reg[s];
                        rd_next[src_is_b(s) ? irq_route_pkg::CTL_EN_B : irq_route_pkg::CTL_EN_A] = en_reg[s];
                    end
                end
                rd_next[irq_route_pkg::CTL_LVL_LSB +: LW] = level_reg[2'(paddr[4:2] - 3'd3)];
                if (paddr == irq_route_pkg::OFS_CTL_PT)
                    rd_next[irq_route_pkg::CTL_RUN] = pt_run_reg;
            end
            irq_route_pkg::OFS_TB_REF0: rd_next[TB_W-1:0] = tb_ref0_reg;
            irq_route_pkg::OFS_TB_REF1: rd_next[TB_W-1:0] = tb_ref1_reg;
            irq_route_pkg::OFS_RTC_ALARM: rd_next[RTC_W-1:0] = rtc_alarm_value;
            irq_route_pkg::OFS_PT_RELOAD: rd_next[irq_route_pkg::PT_W-1:0] = pt_reload_reg;
            irq_route_pkg::OFS_TIO_LVL0: rd_next[LW-1:0] = tio_bank0_level;
            irq_route_pkg::OFS_TIO_LVL1: rd_next[LW-1:0] = tio_bank1_level;
            irq_route_pkg::OFS_TIO_EN0: rd_next = tio_bank0_enables;
            irq_route_pkg::OFS_TIO_EN1: rd_next = tio_bank1_enables;
            irq_route_pkg::OFS_TIO_FLG0: rd_next = tio_bank0_flags & irq_route_pkg::TIO_VALID0;
            irq_route_pkg::OFS_TIO_FLG1: rd_next = tio_bank1_flags & irq_route_pkg::TIO_VALID1;
            default: rd_next = irq_route_pkg::RST_ZERO;
        endcase
    end

    // read data caught in the setup cycle so it comes from a flop with no wait state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= irq_route_pkg::RST_ZERO;
        else if (psel && !penable && !pwrite)
            prdata_reg <= rd_next;
    end
    assign prdata = prdata_reg;

    // software configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            interrupt_mask_register <= irq_route_pkg::RST_ZERO;
            edge_mode_reg <= '0;
            tb_ref0_reg <= '0;
            tb_ref1_reg <= '0;
            rtc_alarm_value <= '0;
            pt_reload_reg <= irq_route_pkg::PT_RST_RELOAD;
            tio_bank0_level <= '0;
            tio_bank1_level <= '0;
            tio_bank0_enables <= irq_route_pkg::RST_ZERO;
            tio_bank1_enables <= irq_route_pkg::RST_ZERO;
        end
        else if (wr)
        begin
            case (paddr)
                irq_route_pkg::OFS_MASK: interrupt_mask_register <= pwdata;
                irq_route_pkg::OFS_EDGE: edge_mode_reg <= pwdata[NP-1:0];
                irq_route_pkg::OFS_TB_REF0: tb_ref0_reg <= pwdata[TB_W-1:0];
                irq_route_pkg::OFS_TB_REF1: tb_ref1_reg <= pwdata[TB_W-1:0];
                irq_route_pkg::OFS_RTC_ALARM: rtc_alarm_value <= pwdata[RTC_W-1:0];
                irq_route_pkg::OFS_PT_RELOAD: pt_reload_reg <= pwdata[irq_route_pkg::PT_W-1:0];
                irq_route_pkg::OFS_TIO_LVL0: tio_bank0_level <= pwdata[LW-1:0];
                irq_route_pkg::OFS_TIO_LVL1: tio_bank1_level <= pwdata[LW-1:0];
                irq_route_pkg::OFS_TIO_EN0: tio_bank0_enables <= pwdata & irq_route_pkg::TIO_VALID0;
                irq_route_pkg::OFS_TIO_EN1: tio_bank1_enables <= pwdata & irq_route_pkg::TIO_VALID1;
                default: interrupt_mask_register <= interrupt_mask_register;
            endcase
        end
    end

    // source flags, enables and levels; a new event beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_reg <= '0;
            en_reg <= '0;
            pt_run_reg <= 1'b0;
            for (int g = 0; g < irq_route_pkg::NUM_GRP; g++)
                level_reg[g] <= '0;
        end
        else
        begin
            for (int s = 0; s < NS; s++)
            begin
                if (set_evt[s])
                    flag_reg[s] <= 1'b1;
                else if (wr && int'(paddr[4:2]) - 3 == src_grp(s) && paddr >= irq_route_pkg::OFS_CTL_TB
                         && paddr <= irq_route_pkg::OFS_CTL_LOCK
                         && pwdata[src_is_b(s) ? irq_route_pkg::CTL_FLAG_B : irq_route_pkg::CTL_FLAG_A])
                    flag_reg[s] <= 1'b0;
                if (wr && int'(paddr[4:2]) - 3 == src_grp(s) && paddr >= irq_route_pkg::OFS_CTL_TB
                    && paddr <= irq_route_pkg::OFS_CTL_LOCK)
                    en_reg[s] <= pwdata[src_is_b(s) ? irq_route_pkg::CTL_EN_B : irq_route_pkg::CTL_EN_A];
            end
            if (wr && paddr >= irq_route_pkg::OFS_CTL_TB && paddr <= irq_route_pkg::OFS_CTL_LOCK)
                level_reg[2'(paddr[4:2] - 3'd3)] <= pwdata[irq_route_pkg::CTL_LVL_LSB +: LW];
            if (wr && paddr == irq_route_pkg::OFS_CTL_PT)
                pt_run_reg <= pwdata[irq_route_pkg::CTL_RUN];
        end
    end

    // periodic down-counter, reloads as it passes zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pt_count_reg <= irq_route_pkg::PT_RST_RELOAD;
        else if (!pt_run_reg)
            pt_count_reg <= pt_reload_reg;
        else if (pt_count_reg == '0)
            pt_count_reg <= pt_reload_reg;
        else
            pt_count_reg <= pt_count_reg - 1'b1;
    end

    // lock history; first sample only arms the detector so reset gives no false change
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_prev_reg <= 1'b0;
            lock_seen_reg <= 1'b0;
        end
        else
        begin
            lock_prev_reg <= pll_locked;
            lock_seen_reg <= 1'b1;
        end
    end

    // request pins: latched on falling edge, or live while low in level mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_prev_reg <= '1;
            pin_pend_reg <= '0;
        end
        else
        begin
            pin_prev_reg <= irq_pin_n;
            for (int i = 0; i < NP; i++)
            begin
                if (!edge_mode_reg[i])
                    pin_pend_reg[i] <= !irq_pin_n[i];
                else if (pin_prev_reg[i] && !irq_pin_n[i])
                    pin_pend_reg[i] <= 1'b1;
                else if (w1c_pin[i])
                    pin_pend_reg[i] <= 1'b0;
            end
        end
    end

    // core request; pin zero has its own vector and never passes the mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(interrupt_pending_register & interrupt_mask_register & ~irq_route_pkg::PIN0_BIT);
    end
    assign irq_req = irq_reg;
    assign nmi_req = pin_pend_reg[0];

    // checks; pins first, then internal sources and timer banks, then mask and pending bits, last the lock flag at rest

    nmi_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        edge_mode_reg[0] && pin_prev_reg[0] && !irq_pin_n[0] |=> nmi_req && interrupt_pending_register[31])
        else $error("pin zero edge did not raise nmi");
    pin_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        !edge_mode_reg[2] && !irq_pin_n[2] && $stable(edge_mode_reg) |=> interrupt_pending_register[27])
        else $error("held low pin not pending");
    tb_match0_a: assert property (@(posedge pclk) disable iff (!presetn)
        tb_count == tb_ref0_reg ##1 en_reg[0] |-> lvl_req[level_reg[0]])
        else $error("time base match zero not requested");
    tb_match1_a: assert property (@(posedge pclk) disable iff (!presetn)
        tb_count == tb_ref1_reg |=> flag_reg[1])
        else $error("time base match one flag missing");
    rtc_alarm_a: assert property (@(posedge pclk) disable iff (!presetn)
        rtc_count == rtc_alarm_value |=> flag_reg[2])
        else $error("alarm flag missing");
    rtc_seconds_a: assert property (@(posedge pclk) disable iff (!presetn)
        rtc_second_tick ##1 en_reg[3] |-> lvl_req[level_reg[1]])
        else $error("seconds event not requested");
    pt_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        pt_run_reg && pt_count_reg == '0 |=> flag_reg[4] && pt_count_reg == $past(pt_reload_reg))
        else $error("periodic zero not handled");
    lock_change_a: assert property (@(posedge pclk) disable iff (!presetn)
        lock_seen_reg && $changed(pll_locked) |=> flag_reg[5])
        else $error("lock change flag missing");
    src_gating_a: assert property (@(posedge pclk) disable iff (!presetn)
        lvl_req == 8'h00 |-> (flag_reg & en_reg) == '0 && !tio0_act && !tio1_act)
        else $error("active source gave no level");
    tio_bank_a: assert property (@(posedge pclk) disable iff (!presetn)
        tio1_act |-> lvl_req[tio_bank1_level] && interrupt_pending_register[30 - 2 * tio_bank1_level])
        else $error("bank one flag not requested");
    mask_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        (interrupt_pending_register & interrupt_mask_register) == 32'h00100000 |=> irq_req)
        else $error("level five unmasked gave no request");
    nmi_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
        (interrupt_pending_register & interrupt_mask_register & ~irq_route_pkg::PIN0_BIT) == '0 |=> !irq_req)
        else $error("request without unmasked pending bit");
    pin_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        edge_mode_reg[1] && w1c_pin[1] && !(pin_prev_reg[1] && !irq_pin_n[1]) |=> !interrupt_pending_register[29])
        else $error("pin one pending not cleared");
    pend_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        interrupt_pending_register[15:0] == 16'h0000)
        else $error("reserved pending bits set");
    lock_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        lock_seen_reg && !$changed(pll_locked) && !(wr && paddr == irq_route_pkg::OFS_CTL_LOCK)
        |=> flag_reg[5] == $past(flag_reg[5]))
        else $error("lock flag moved without a change");
endmodule // interrupt_source_routing

// ---- sim/core_model.sv ----
// behavioural core side: counts requests taken on the two core inputs
module core_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // requests from the router
    input wire logic irq_req,
    input wire logic nmi_req,
    // taken counts
    output logic [15:0] ext_cnt,
    output logic [15:0] nmi_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic irq_d;
    logic nmi_d;
    // the core takes a level request once per rising level, as a handler would
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_d <= 1'b0;
            nmi_d <= 1'b0;
            ext_cnt <= 16'h0000;
            nmi_cnt <= 16'h0000;
        end
        else
        begin
            irq_d <= irq_req;
            nmi_d <= nmi_req;
            if (irq_req && !irq_d)
                ext_cnt <= ext_cnt + 16'h0001;
            if (nmi_req && !nmi_d)
                nmi_cnt <= nmi_cnt + 16'h0001;
        end
    end
endmodule // core_model

// ---- sim/interrupt_source_routing_tb_top.sv ----
// self-checking bench for the interrupt source router
module interrupt_source_routing_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rtc_second_tick, pll_locked, irq_req, nmi_req;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, tb_count, rtc_count, tio_bank0_flags, tio_bank1_flags, rv;
    logic [7:0] irq_pin_n;
    logic [15:0] ext_cnt, nmi_cnt;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    interrupt_source_routing dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_pin_n(irq_pin_n), .tb_count(tb_count), .rtc_count(rtc_count), .rtc_second_tick(rtc_second_tick),
        .pll_locked(pll_locked), .tio_bank0_flags(tio_bank0_flags), .tio_bank1_flags(tio_bank1_flags),
        .irq_req(irq_req), .nmi_req(nmi_req));
    core_model u_core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .nmi_req(nmi_req),
        .ext_cnt(ext_cnt), .nmi_cnt(nmi_cnt));
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic report_and_stop();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // hang guard, well above the roughly seven hundred and eighty cycles the tests need
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer; an idle cycle before it keeps drivers from double assignment
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
        output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic e;
        apb(1'b1, a, d, x, e);
    endtask
    task automatic rd(input logic [7:0] a);
        logic e;
        apb(1'b0, a, 32'h00000000, rv, e);
    endtask
    function automatic logic [31:0] pin_bit(input int i);
        return 32'h80000000 >> (2 * i);
    endfunction
    function automatic logic [31:0] lvl_bit(input int l);
        return 32'h40000000 >> (2 * l);
    endfunction
    // one internal source: program, fire, check flag, pending level and core request, clear
    task automatic src_case(input int s, input logic en, input logic [2:0] lvl);
        logic [7:0] ca;
        int fb;
        logic [31:0] ctl, r;
        ca = (s <= irq_route_pkg::SRC_TB1) ? irq_route_pkg::OFS_CTL_TB : (s <= irq_route_pkg::SRC_SEC) ?
            irq_route_pkg::OFS_CTL_RTC : (s == irq_route_pkg::SRC_PT) ? irq_route_pkg::OFS_CTL_PT :
            irq_route_pkg::OFS_CTL_LOCK;
        fb = (s == irq_route_pkg::SRC_TB1 || s == irq_route_pkg::SRC_SEC) ? irq_route_pkg::CTL_FLAG_B :
            irq_route_pkg::CTL_FLAG_A;
        ctl = (32'(en) << (fb + 2)) | (32'(lvl) << irq_route_pkg::CTL_LVL_LSB);
        if (s == irq_route_pkg::SRC_PT)
            ctl = ctl | (32'h00000001 << irq_route_pkg::CTL_RUN);
        r = $urandom;
        wr(irq_route_pkg::OFS_MASK, lvl_bit(lvl));
        case (s)
            irq_route_pkg::SRC_TB0: wr(irq_route_pkg::OFS_TB_REF0, r);
            irq_route_pkg::SRC_TB1: wr(irq_route_pkg::OFS_TB_REF1, r);
            irq_route_pkg::SRC_ALARM: wr(irq_route_pkg::OFS_RTC_ALARM, r);
            irq_route_pkg::SRC_PT: wr(irq_route_pkg::OFS_PT_RELOAD, 32'h00000014);
            default: ;
        endcase
        wr(ca, ctl);
        @(posedge pclk);
        case (s)
            irq_route_pkg::SRC_TB0, irq_route_pkg::SRC_TB1: tb_count <= r;
            irq_route_pkg::SRC_ALARM: rtc_count <= r;
            irq_route_pkg::SRC_SEC: rtc_second_tick <= 1'b1;
            irq_route_pkg::SRC_LOCK: pll_locked <= ~pll_locked;
            default: ;
        endcase
        @(posedge pclk);
        tb_count <= r + 32'h1;
        rtc_count <= r + 32'h1;
        rtc_second_tick <= 1'b0;
        if (s == irq_route_pkg::SRC_PT)
        begin
            rd(ca);
            chk(32'(rv[fb]), 32'h0, "periodic flag early");
            tick(20);
        end
        tick(3);
        rd(ca);
        chk(32'(rv[fb]), 32'h1, "source flag");
        rd(irq_route_pkg::OFS_PEND);
        chk(rv, en ? lvl_bit(lvl) : 32'h0, "pending level");
        chk(32'(irq_req), 32'(en), "core request");
        wr(ca, 32'h0);
        wr(ca, 32'h1 << fb);
        rd(irq_route_pkg::OFS_PEND);
        chk(rv, 32'h0, "pending after clear");
    endtask
    initial
    begin
        logic e;
        int b;
        logic [2:0] l;
        logic [31:0] en, fl, vm;
        {psel, penable, pwrite, rtc_second_tick, pll_locked} = 5'b00000;
        paddr = 8'h00;
        pwdata = 32'h0;
        irq_pin_n = 8'hFF;
        {tb_count, rtc_count} = {32'h1, 32'h1};
        {tio_bank0_flags, tio_bank1_flags} = {32'h0, 32'h0};
        presetn = 1'b0;
        void'($urandom(13));
        tick(16);
        presetn <= 1'b1;
        rd(irq_route_pkg::OFS_PEND);
        chk(rv, 32'h0, "pending reset");
        chk({30'h0, irq_req, nmi_req}, 32'h0, "requests reset");
        apb(1'b0, 8'h44, 32'h0, rv, e);
        chk({rv[31:1], e}, 32'h1, "unmapped read");
        apb(1'b0, 8'h06, 32'h0, rv, e);
        chk({rv[31:1], e}, 32'h1, "misaligned read");
        // pins: even ones level mode held low, odd ones a one-cycle falling edge
        for (int i = 0; i < 8; i++)
        begin
            wr(irq_route_pkg::OFS_EDGE, 32'(i % 2) << i);
            wr(irq_route_pkg::OFS_MASK, ~pin_bit(i));
            @(posedge pclk);
            irq_pin_n[i] <= 1'b0;
            @(posedge pclk);
            if (i % 2 == 1)
                irq_pin_n[i] <= 1'b1;
            tick(3);
            chk(32'(irq_req), 32'h0, "masked pin");
            chk(32'(nmi_req), 32'(i == 0), "pin zero nmi");
            wr(irq_route_pkg::OFS_MASK, pin_bit(i));
            tick(2);
            chk(32'(irq_req), 32'(i != 0), "unmasked pin");
            rd(irq_route_pkg::OFS_PEND);
            chk(rv, pin_bit(i), "pin pending bit");
            @(posedge pclk);
            irq_pin_n[i] <= 1'b1;
            if (i % 2 == 1)
                wr(irq_route_pkg::OFS_PEND, pin_bit(i));
            tick(3);
            rd(irq_route_pkg::OFS_PEND);
            chk(rv, 32'h0, "pin released");
        end
        // pin zero in edge mode: latched, still non-maskable, cleared through its pending bit
        wr(irq_route_pkg::OFS_EDGE, 32'h00000001);
        @(posedge pclk);
        irq_pin_n[0] <= 1'b0;
        @(posedge pclk);
        irq_pin_n[0] <= 1'b1;
        tick(2);
        chk(32'(nmi_req), 32'h1, "pin zero edge nmi");
        rd(irq_route_pkg::OFS_PEND);
        chk(rv, pin_bit(0), "pin zero edge pending");
        wr(irq_route_pkg::OFS_PEND, pin_bit(0));
        tick(1);
        chk(32'(nmi_req), 32'h0, "pin zero cleared");
        chk(32'(nmi_cnt), 32'h2, "nmis taken");
        chk(32'(ext_cnt), 32'h7, "core requests taken");
        // internal sources, each disabled once and enabled once at a random level
        for (int k = 0; k < 12; k++)
        begin
            // level five alone once, as the mask example has it
            l = (k == 1) ? 3'h5 : 3'($urandom);
            src_case(k / 2, 1'(k % 2), l);
        end
        // timer banks with random enables and flags
        for (int k = 0; k < 8; k++)
        begin
            b = k % 2;
            l = 3'($urandom);
            en = (k < 2) ? 32'h0 : $urandom;
            fl = $urandom & $urandom;
            vm = b ? irq_route_pkg::TIO_VALID1 : irq_route_pkg::TIO_VALID0;
            wr(b ? irq_route_pkg::OFS_TIO_LVL1 : irq_route_pkg::OFS_TIO_LVL0, 32'(l));
            wr(b ? irq_route_pkg::OFS_TIO_EN1 : irq_route_pkg::OFS_TIO_EN0, en);
            wr(irq_route_pkg::OFS_MASK, lvl_bit(l));
            @(posedge pclk);
            tio_bank0_flags <= b ? 32'h0 : fl;
            tio_bank1_flags <= b ? fl : 32'h0;
            rd(b ? irq_route_pkg::OFS_TIO_EN1 : irq_route_pkg::OFS_TIO_EN0);
            chk(rv, en & vm, "bank enables");
            rd(irq_route_pkg::OFS_PEND);
            chk(rv, ((fl & en & vm) != 0) ? lvl_bit(l) : 32'h0, "bank level");
            chk(32'(irq_req), 32'((fl & en & vm) != 0), "bank request");
            @(posedge pclk);
            {tio_bank0_flags, tio_bank1_flags} <= {32'h0, 32'h0};
        end
        tick(4);
        report_and_stop();
    end
endmodule // interrupt_source_routing_tb_top
